/* File: verilog/t16c_top.sv */
// 16-bit timer slice: input capture with noise filter and fast pwm counting, apb slave
`timescale 1ns/1ps
// Notes on behaviour
// RL1: capture pin default, comparator when selected
// RL2: software clears capture flag after source change
// RL3: filter output changes after four equal samples
// RL4: filter adds four system clocks, ignores prescaler
// RL5: capture idle only when capture register sets top
// RL6: software-driven pin levels also trigger capture
// RL7: each capture overwrites the capture register
// RL8: software writes high byte before low byte
// RL9: software sets waveform mode before top write
// RL10: top ranges from 0x0003 to 0xFFFF
// RL11: modes 5,6,7 top at 0x00FF,0x01FF,0x03FF
// RL12: mode 14 top capture, mode 15 compare A
// RL13: counter clears the timer tick after top
// RL14: counter equal to compare sets its flag
// RL15: overflow flag set whenever counter reaches top
// RL16: top register flag set with overflow flag
// RL17: software keeps top at or above compares
// RL18: fixed-top modes mask high compare bits on write
// RL19: capture top unbuffered, may wrap past 0xFFFF
// RL20: compare A double buffered in pwm modes
// RL21: software flips capture edge after each read
// RL22: trigger edge copies counter, sets capture flag
module t16c_top (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CAPTURE_INPUT_PIN,
	input wire logic COMPARATOR_OUTPUT,
	input wire logic EXTERNAL_COUNT_PIN,
	output logic [15:0] COUNTER_VALUE,
	output logic TOP_PULSE,
	output logic COMPARE_A_PULSE,
	output logic COMPARE_B_PULSE
);
	t16c_pkg::t16c_ctrl_type ctrl_q, ctrl_d;
	logic [15:0] cnt_q, cnt_d;
	logic [1:0][15:0] cmp_buf_q, cmp_buf_d;
	logic [1:0][15:0] cmp_act_q, cmp_act_d;
	logic [15:0] cap_q, cap_d;
	logic [7:0] tmp_q, tmp_d;
	logic [3:0] flg_q, flg_d;
	logic [9:0] psc_q, psc_d;
	logic ext_prev_q, ext_prev_d;
	logic edge_prev_q, edge_prev_d;
	logic [31:0] rdata_q, rdata_d;
	logic slverr_q, slverr_d;
	logic [2:0] evt_q, evt_d;

	logic icp_s, aco_s, ext_s;
	logic trig_src, trig_filt;
	logic cap_en, cap_edge;
	logic tick;
	logic [15:0] top_v;
	logic fixed_top, pwm_mode, at_top;
	logic [1:0] cmp_hit;
	logic setup, access, wr, rd;
	logic cnt_wr;
	logic [3:0] flg_set, flg_clr;

	// pin and comparator levels enter from outside; pin level may be software-driven
	t16c_sync2 u_sync_icp (.clk(CLK), .srst(SRST), .din(CAPTURE_INPUT_PIN), .dout(icp_s)); // RL6
	t16c_sync2 u_sync_aco (.clk(CLK), .srst(SRST), .din(COMPARATOR_OUTPUT), .dout(aco_s));
	t16c_sync2 u_sync_ext (.clk(CLK), .srst(SRST), .din(EXTERNAL_COUNT_PIN), .dout(ext_s));

	// source switch can itself look like an edge; software clears the flag after
	assign trig_src = ctrl_q.cmp_sel ? aco_s : icp_s; // RL1

	// filter runs on the system clock, not on the prescaled tick
	t16c_filt u_filt (.clk(CLK), .srst(SRST), .en(ctrl_q.filt_en), .din(trig_src), .dout(trig_filt)); // RL4

	// edge detector, idle while the capture register is top
	always_comb begin
		cap_en = (ctrl_q.wmode != t16c_pkg::MODE_FPWM_CAPT); // RL5
		edge_prev_d = trig_filt;
		cap_edge = cap_en && (ctrl_q.edge_rise ? (trig_filt && !edge_prev_q) : (!trig_filt && edge_prev_q));
	end

	// apb phases
	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE;
	assign wr = access && PWRITE;
	assign rd = access && !PWRITE;
	assign cnt_wr = wr && (PADDR == t16c_pkg::ADDR_COUNT);

	// prescaler taps and external clock edges
	always_comb begin
		psc_d = psc_q + 10'h001;
		ext_prev_d = ext_s;
		unique case (t16c_pkg::t16c_clksel_type'(ctrl_q.clk_sel))
			t16c_pkg::CS_STOP: tick = 1'b0;
			t16c_pkg::CS_DIV1: tick = 1'b1;
			t16c_pkg::CS_DIV8: tick = (psc_q & t16c_pkg::PSC_MASK8) == t16c_pkg::PSC_MASK8;
			t16c_pkg::CS_DIV64: tick = (psc_q & t16c_pkg::PSC_MASK64) == t16c_pkg::PSC_MASK64;
			t16c_pkg::CS_DIV256: tick = (psc_q & t16c_pkg::PSC_MASK256) == t16c_pkg::PSC_MASK256;
			t16c_pkg::CS_DIV1024: tick = (psc_q & t16c_pkg::PSC_MASK1024) == t16c_pkg::PSC_MASK1024;
			t16c_pkg::CS_EXT_FALL: tick = ext_prev_q && !ext_s;
			t16c_pkg::CS_EXT_RISE: tick = !ext_prev_q && ext_s;
		endcase
	end

	// top select per waveform mode; other modes free-run to max
	always_comb begin
		top_v = t16c_pkg::TOP_MAX; // RL10
		fixed_top = 1'b1;
		pwm_mode = 1'b1;
		unique case (ctrl_q.wmode)
			t16c_pkg::MODE_FPWM8: top_v = t16c_pkg::TOP_8BIT; // RL11
			t16c_pkg::MODE_FPWM9: top_v = t16c_pkg::TOP_9BIT; // RL11
			t16c_pkg::MODE_FPWM10: top_v = t16c_pkg::TOP_10BIT; // RL11
			t16c_pkg::MODE_FPWM_CAPT: begin
				top_v = cap_q; // RL12 RL19
				fixed_top = 1'b0;
			end
			t16c_pkg::MODE_FPWM_CMPA: begin
				top_v = cmp_act_q[0]; // RL12 RL20
				fixed_top = 1'b0;
			end
			default: begin
				fixed_top = 1'b0;
				pwm_mode = 1'b0;
			end
		endcase
		at_top = (cnt_q == top_v);
		cmp_hit[0] = (cnt_q == cmp_act_q[0]);
		cmp_hit[1] = (cnt_q == cmp_act_q[1]);
	end

	// counter: cpu write first, then clear after top, else count up
	always_comb begin
		cnt_d = cnt_q;
		if (cnt_wr)
			cnt_d = PWDATA[15:0];
		else if (tick && at_top)
			cnt_d = 16'h0000; // RL13
		else if (tick)
			cnt_d = cnt_q + 16'h0001; // RL19 wraps past 0xFFFF
	end

	// compare buffers; active copy follows at top in pwm modes, at once otherwise
	always_comb begin
		cmp_buf_d = cmp_buf_q;
		cmp_act_d = cmp_act_q;
		for (int i = 0; i < 2; i++) begin
			if (wr && (PADDR == (i == 0 ? t16c_pkg::ADDR_CMPA : t16c_pkg::ADDR_CMPB)))
				cmp_buf_d[i] = PWDATA[15:0] & (fixed_top ? top_v : t16c_pkg::TOP_MAX); // RL18
			if (!pwm_mode || (tick && at_top))
				cmp_act_d[i] = cmp_buf_q[i]; // RL20
		end
	end

	// capture register and shared high-byte temp
	always_comb begin
		cap_d = cap_q;
		tmp_d = tmp_q;
		if (wr && PADDR == t16c_pkg::ADDR_CAPT_HI)
			tmp_d = PWDATA[7:0]; // RL8
		if (wr && PADDR == t16c_pkg::ADDR_CAPT_LO)
			cap_d = {tmp_q, PWDATA[7:0]}; // RL8
		if (rd && PADDR == t16c_pkg::ADDR_CAPT_LO)
			tmp_d = cap_q[15:8];
		// hardware capture beats a cpu write in the same cycle
		if (cap_edge)
			cap_d = cnt_q; // RL7 RL22
	end

	// flags: hardware set wins over write-one-to-clear
	always_comb begin
		flg_set = '0;
		flg_set[t16c_pkg::FLG_OVF] = tick && at_top; // RL15
		flg_set[t16c_pkg::FLG_CMPA] = tick && cmp_hit[0]; // RL14 RL16
		flg_set[t16c_pkg::FLG_CMPB] = tick && cmp_hit[1]; // RL14
		flg_set[t16c_pkg::FLG_CAPT] = cap_edge ||
			(tick && at_top && ctrl_q.wmode == t16c_pkg::MODE_FPWM_CAPT); // RL16 RL22
		flg_clr = (wr && PADDR == t16c_pkg::ADDR_FLAGS) ? PWDATA[3:0] : 4'h0;
		flg_d = (flg_q & ~flg_clr) | flg_set;
		evt_d = {tick && cmp_hit[1], tick && cmp_hit[0], tick && at_top};
	end

	// control register and read mux, read data latched in the setup cycle
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr && PADDR == t16c_pkg::ADDR_CTRL)
			ctrl_d = t16c_pkg::t16c_ctrl_type'(PWDATA[t16c_pkg::CTRL_W-1:0]);
		rdata_d = rdata_q;
		slverr_d = slverr_q;
		if (setup) begin
			slverr_d = 1'b0;
			unique case (PADDR)
				t16c_pkg::ADDR_CTRL: rdata_d = {22'h000000, ctrl_q};
				t16c_pkg::ADDR_COUNT: rdata_d = {16'h0000, cnt_q};
				t16c_pkg::ADDR_CMPA: rdata_d = {16'h0000, cmp_buf_q[0]};
				t16c_pkg::ADDR_CMPB: rdata_d = {16'h0000, cmp_buf_q[1]};
				t16c_pkg::ADDR_CAPT_LO: rdata_d = {24'h000000, cap_q[7:0]};
				t16c_pkg::ADDR_CAPT_HI: rdata_d = {24'h000000, tmp_q};
				t16c_pkg::ADDR_FLAGS: rdata_d = {28'h0000000, flg_q};
				t16c_pkg::ADDR_STATUS: rdata_d = {29'h00000000, cap_en, trig_src, trig_filt};
				default: begin
					rdata_d = 32'h00000000;
					slverr_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl_q <= t16c_pkg::t16c_ctrl_type'(t16c_pkg::CTRL_RST);
			cnt_q <= 16'h0000;
			cmp_buf_q <= '0;
			cmp_act_q <= '0;
			cap_q <= 16'h0000;
			tmp_q <= 8'h00;
			flg_q <= 4'h0;
			psc_q <= 10'h000;
			ext_prev_q <= 1'b0;
			edge_prev_q <= 1'b0;
			rdata_q <= 32'h00000000;
			slverr_q <= 1'b0;
			evt_q <= 3'h0;
		end else begin
			ctrl_q <= ctrl_d;
			cnt_q <= cnt_d;
			cmp_buf_q <= cmp_buf_d;
			cmp_act_q <= cmp_act_d;
			cap_q <= cap_d;
			tmp_q <= tmp_d;
			flg_q <= flg_d;
			psc_q <= psc_d;
			ext_prev_q <= ext_prev_d;
			edge_prev_q <= edge_prev_d;
			rdata_q <= rdata_d;
			slverr_q <= slverr_d;
			evt_q <= evt_d;
		end
	end

	// zero wait states; error only on unmapped offsets
	assign PREADY = PENABLE;
	assign PRDATA = rdata_q;
	assign PSLVERR = slverr_q;
	assign COUNTER_VALUE = cnt_q;
	assign TOP_PULSE = evt_q[0];
	assign COMPARE_A_PULSE = evt_q[1];
	assign COMPARE_B_PULSE = evt_q[2];

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	// source mux must follow the select bit on every cycle, not only after a switch
	a_src_pin: assert property (!ctrl_q.cmp_sel |-> trig_src == icp_s) // RL1
		else $error("capture source is not the pin while the pin is selected");
	a_src_cmp: assert property (ctrl_q.cmp_sel |-> trig_src == aco_s) // RL1
		else $error("capture source is not the comparator while it is selected");
	a_capture_copy: assert property (cap_edge |=> cap_q == $past(cnt_q) && flg_q[t16c_pkg::FLG_CAPT]) // RL22
		else $error("capture edge did not store count and set flag");
	a_capture_over: assert property (cap_edge && flg_q[t16c_pkg::FLG_CAPT] |=> cap_q == $past(cnt_q)) // RL7
		else $error("pending capture blocked an overwrite");
	a_capture_off: assert property (ctrl_q.wmode == t16c_pkg::MODE_FPWM_CAPT |-> !cap_edge) // RL5
		else $error("capture fired while capture register is top");
	a_top_clear: assert property (tick && at_top && !cnt_wr |=> cnt_q == 16'h0000) // RL13
		else $error("counter not cleared after top");
	a_fixed_top: assert property (ctrl_q.wmode == t16c_pkg::MODE_FPWM9 && tick && !cnt_wr // RL11
		&& cnt_q == 16'h01FF |=> cnt_q == 16'h0000 && flg_q[t16c_pkg::FLG_OVF])
		else $error("9-bit mode did not wrap at 0x01FF");
	a_ovf_flag: assert property (tick && at_top |=> flg_q[t16c_pkg::FLG_OVF]) // RL15
		else $error("overflow flag missing at top");
	a_cmp_flag: assert property (tick && cnt_q == cmp_act_q[1] |=> flg_q[t16c_pkg::FLG_CMPB]) // RL14
		else $error("compare flag missing on match");
	a_top_pair: assert property (ctrl_q.wmode == t16c_pkg::MODE_FPWM_CMPA && tick && at_top // RL16
		|=> flg_q[t16c_pkg::FLG_CMPA] && flg_q[t16c_pkg::FLG_OVF])
		else $error("compare A flag not paired with overflow");
	a_mask_write: assert property (fixed_top && wr && PADDR == t16c_pkg::ADDR_CMPA // RL18
		|=> (cmp_buf_q[0] & ~$past(top_v)) == 16'h0000)
		else $error("compare bits above resolution kept");
	a_cmpa_buffer: assert property (pwm_mode && !(tick && at_top) |=> $stable(cmp_act_q[0])) // RL20
		else $error("active compare A changed away from top");
	a_capt_wrap: assert property (ctrl_q.wmode == t16c_pkg::MODE_FPWM_CAPT && tick && !wr // RL19
		&& cnt_q == 16'hFFFF && cap_q != 16'hFFFF |=> cnt_q == 16'h0000 && $stable(flg_q[t16c_pkg::FLG_OVF]))
		else $error("counter did not wrap past max below top");
	a_min_top: assert property (ctrl_q.wmode == t16c_pkg::MODE_FPWM_CMPA && cmp_act_q[0] == t16c_pkg::TOP_MIN // RL10
		&& tick && at_top && !cnt_wr |=> cnt_q == 16'h0000)
		else $error("two-bit pwm did not wrap at 0x0003");
	// top register flag pairs with overflow in capture-top mode as well
	a_capt_pair: assert property (ctrl_q.wmode == t16c_pkg::MODE_FPWM_CAPT && tick && at_top // RL16
		|=> flg_q[t16c_pkg::FLG_CAPT] && flg_q[t16c_pkg::FLG_OVF])
		else $error("capture flag not paired with overflow");
	a_top_pulse: assert property (tick && at_top |=> TOP_PULSE) // RL15
		else $error("top pulse missing after top");
	// a cpu write to the counter wins over clear and count
	a_cnt_write: assert property (cnt_wr |=> cnt_q == $past(PWDATA[15:0])) // RL13
		else $error("counter write lost to clear or count");
	a_cmpb_buffer: assert property (pwm_mode && !(tick && at_top) |=> $stable(cmp_act_q[1])) // RL20
		else $error("active compare B changed away from top");
endmodule : t16c_top

/* File: verilog/t16c_pkg.sv */
// constants, register map and field layout of the 16-bit capture / fast pwm timer
package t16c_pkg;
	// apb register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_CMPA = 8'h08;
	localparam logic [7:0] ADDR_CMPB = 8'h0C;
	localparam logic [7:0] ADDR_CAPT_LO = 8'h10;
	localparam logic [7:0] ADDR_CAPT_HI = 8'h14;
	localparam logic [7:0] ADDR_FLAGS = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;

	// control word, bit 0 is wmode[0]
	typedef struct packed {
		logic cmp_sel;
		logic [2:0] clk_sel;
		logic edge_rise;
		logic filt_en;
		logic [3:0] wmode;
	} t16c_ctrl_type;
	localparam int CTRL_W = 10;
	localparam logic [9:0] CTRL_RST = 10'h000;

	// flag register bit positions
	localparam int FLG_OVF = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CAPT = 3;

	// waveform modes handled as fast pwm
	localparam logic [3:0] MODE_FPWM8 = 4'h5;
	localparam logic [3:0] MODE_FPWM9 = 4'h6;
	localparam logic [3:0] MODE_FPWM10 = 4'h7;
	localparam logic [3:0] MODE_FPWM_CAPT = 4'hE;
	localparam logic [3:0] MODE_FPWM_CMPA = 4'hF;

	// top values
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_MIN = 16'h0003;

	// prescaler tap masks and clock select codes
	localparam logic [9:0] PSC_MASK8 = 10'h007;
	localparam logic [9:0] PSC_MASK64 = 10'h03F;
	localparam logic [9:0] PSC_MASK256 = 10'h0FF;
	localparam logic [9:0] PSC_MASK1024 = 10'h3FF;
	typedef enum logic [2:0] {
		CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
	} t16c_clksel_type;

	// noise filter: samples that must agree, and extra delay in clk cycles
	localparam int FILT_SAMPLES = 4;
	localparam int FILT_DELAY = 4;
endpackage : t16c_pkg

/* File: verilog/t16c_sync2.sv */
// two-flop synchroniser for a level coming from outside the clock domain
`timescale 1ns/1ps
module t16c_sync2 (
	input wire logic clk,
	input wire logic srst,
	input wire logic din,
	output logic dout
);
	logic meta_q, meta_d;
	logic sync_q, sync_d;

	// meta_q is read only by sync_q
	always_comb begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;
endmodule : t16c_sync2

/* File: verilog/t16c_filt.sv */
// capture noise filter: output follows input only after four equal samples
`timescale 1ns/1ps
module t16c_filt (
	input wire logic clk,
	input wire logic srst,
	input wire logic en,
	input wire logic din,
	output logic dout
);
	logic [t16c_pkg::FILT_SAMPLES-2:0] hist_q, hist_d;
	logic out_q, out_d;
	logic agree;

	// current input plus three history samples must agree
	always_comb begin
		hist_d = {hist_q[t16c_pkg::FILT_SAMPLES-3:0], din};
		agree = (hist_q == {(t16c_pkg::FILT_SAMPLES-1){din}});
		out_d = out_q;
		if (!en)
			out_d = din; // tracks while off, so enabling makes no false edge
		else if (agree)
			out_d = din; // RL3
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			hist_q <= '0;
			out_q <= 1'b0;
		end else begin
			hist_q <= hist_d;
			out_q <= out_d;
		end
	end

	// filtered path is four cycles behind the bypass path
	assign dout = en ? out_q : din; // RL4

	a_filt_hold: assert property (@(posedge clk) disable iff (srst) // RL3
		en && $past(en) && !agree |=> $stable(out_q))
		else $error("filter output moved without four agreeing samples");
	a_filt_delay: assert property (@(posedge clk) disable iff (srst) // RL4
		en && $rose(din) ##1 (en && din)[*3] |=> out_q)
		else $error("filter output not updated four cycles after a stable change");
endmodule : t16c_filt

/* File: test/t16c_pin_model.sv */
// partner model: capture pin and comparator output levels
`timescale 1ns/1ps
module t16c_pin_model (
	input wire logic clk,
	input wire logic pin_req,
	input wire logic cmp_req,
	output logic pin,
	output logic cmp
);
	// both sources start low, so the synchronisers see no edge at reset release
	initial begin
		pin = 1'b0;
		cmp = 1'b0;
	end
	// levels move just after an edge, never on the sampling instant
	always @(posedge clk) begin
		pin <= pin_req;
		cmp <= cmp_req;
	end
endmodule : t16c_pin_model

/* File: test/t16c_top_bench.sv */
// self-checking bench for the capture / fast pwm timer
`timescale 1ns/1ps
module t16c_top_bench;
	logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, rerr, pin_req = 1'b0, cmp_req = 1'b0, pin, cmp, top_p, cmpa_p, cmpb_p;
	logic [15:0] cnt;
	int err_count = 0, num_checks = 0;
	always #50 clk = ~clk;
	// count pin tied low: external clock modes are not exercised
	t16c_top i_t16c_top (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.CAPTURE_INPUT_PIN(pin), .COMPARATOR_OUTPUT(cmp), .EXTERNAL_COUNT_PIN(1'b0),
		.COUNTER_VALUE(cnt), .TOP_PULSE(top_p), .COMPARE_A_PULSE(cmpa_p), .COMPARE_B_PULSE(cmpb_p));
	t16c_pin_model i_t16c_pin_model (.clk(clk), .pin_req(pin_req), .cmp_req(cmp_req), .pin(pin), .cmp(cmp));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			check(0, 1, "apb hang");
			print_verdict();
		end
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] ctl(input logic [3:0] m, input logic f, input logic c);
		return {22'h000000, c, t16c_pkg::CS_DIV1, 1'b1, f, m};
	endfunction : ctl
	task automatic wait_cnt(input logic [15:0] v, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cnt !== v && n < lim);
		if (cnt !== v) begin
			check(0, 1, "count wait timeout");
			print_verdict();
		end
	endtask : wait_cnt
	// watch the counter: never above top, cleared right after top
	task automatic observe(input logic [15:0] top, input int n, input logic tie_a);
		logic [15:0] prev, mx;
		int tops;
		prev = ~top;
		mx = 16'h0000;
		tops = 0;
		repeat (n) begin
			@(negedge clk);
			if (prev === top) check(cnt, 16'h0000, "clear after top");
			if (cnt > top) check(cnt, top, "count above top");
			if (cnt > mx) mx = cnt;
			if (top_p === 1'b1) tops++;
			if (tie_a && top_p === 1'b1) check(cmpa_p, 1'b1, "compare a with top");
			if (cmpb_p === 1'b1 && prev !== ~top) check(prev, 16'h0010, "compare b pulse");
			prev = cnt;
		end
		check(mx, top, "count peak");
		check(tops > 0, 1, "top pulse");
	endtask : observe
	task automatic edge_on(input logic p, input logic v, output logic [15:0] c0);
		@(posedge clk);
		if (p)
			pin_req <= v;
		else
			cmp_req <= v;
		@(negedge clk);
		c0 = cnt;
		repeat (14) @(posedge clk);
	endtask : edge_on
	task automatic rd_cap(output logic [15:0] v);
		apb(0, t16c_pkg::ADDR_CAPT_LO, 0);
		v[7:0] = rd[7:0];
		apb(0, t16c_pkg::ADDR_CAPT_HI, 0);
		v[15:8] = rd[7:0];
	endtask : rd_cap
	task automatic t_reset();
		apb(0, t16c_pkg::ADDR_CTRL, 0);
		check(rd, 0, "control reset");
		check({31'h00000000, rerr}, 32'h00000000, "mapped read error");
		apb(0, t16c_pkg::ADDR_FLAGS, 0);
		check(rd, 0, "flags reset");
		apb(0, 8'h20, 0);
		check(rd, 32'h00000000, "unmapped read data");
		check({31'h00000000, rerr}, 32'h00000001, "unmapped read error");
		$display("reset test done");
	endtask : t_reset
	task automatic t_capture();
		logic [15:0] c0, v, lat;
		apb(1, t16c_pkg::ADDR_CTRL, ctl(4'h0, 1'b0, 1'b0));
		apb(1, t16c_pkg::ADDR_FLAGS, 32'hF);
		edge_on(1, 1, c0);
		apb(0, t16c_pkg::ADDR_FLAGS, 0);
		check(rd[t16c_pkg::FLG_CAPT], 1, "capture flag");
		rd_cap(v);
		lat = v - c0;
		// one model cycle plus two synchroniser flops before the edge is seen
		check(lat, 16'h0003, "capture latency");
		apb(1, t16c_pkg::ADDR_FLAGS, 32'hF);
		edge_on(1, 0, c0);
		apb(0, t16c_pkg::ADDR_FLAGS, 0);
		check(rd[t16c_pkg::FLG_CAPT], 0, "falling edge ignored");
		edge_on(1, 1, c0);
		edge_on(1, 0, c0);
		edge_on(1, 1, c0);
		rd_cap(v);
		check(v, 16'(c0 + lat), "second capture overwrites");
		apb(1, t16c_pkg::ADDR_CTRL, ctl(4'h0, 1'b1, 1'b0));
		edge_on(1, 0, c0);
		edge_on(1, 1, c0);
		rd_cap(v);
		check(16'(v - c0), 16'(lat + 16'h0004), "filter delay");
		edge_on(1, 0, c0);
		apb(1, t16c_pkg::ADDR_FLAGS, 32'hF);
		@(posedge clk);
		pin_req <= 1'b1;
		repeat (3) @(posedge clk);
		pin_req <= 1'b0;
		repeat (14) @(posedge clk);
		apb(0, t16c_pkg::ADDR_FLAGS, 0);
		check(rd[t16c_pkg::FLG_CAPT], 0, "short pulse filtered");
		apb(1, t16c_pkg::ADDR_CTRL, ctl(4'h0, 1'b0, 1'b1));
		apb(1, t16c_pkg::ADDR_FLAGS, 32'hF);
		edge_on(1, 1, c0);
		apb(0, t16c_pkg::ADDR_FLAGS, 0);
		check(rd[t16c_pkg::FLG_CAPT], 0, "pin ignored");
		edge_on(0, 1, c0);
		rd_cap(v);
		check(v, 16'(c0 + lat), "comparator capture");
		// falling edge selected, as software does between duty-cycle captures
		apb(1, t16c_pkg::ADDR_CTRL, ctl(4'h0, 1'b0, 1'b1) & ~32'h00000020);
		apb(1, t16c_pkg::ADDR_FLAGS, 32'hF);
		edge_on(0, 0, c0);
		rd_cap(v);
		check(v, 16'(c0 + lat), "falling edge capture");
		// divide by eight: any 80 cycles hold exactly ten timer ticks
		apb(1, t16c_pkg::ADDR_CTRL, (ctl(4'h0, 1'b0, 1'b0) & ~32'h000001C0) | 32'h00000080);
		@(negedge clk);
		c0 = cnt;
		repeat (80) @(negedge clk);
		check(16'(cnt - c0), 16'h000A, "prescaled count");
		$display("capture test done");
	endtask : t_capture
	task automatic t_fixed();
		logic [15:0] tops [3] = '{t16c_pkg::TOP_8BIT, t16c_pkg::TOP_9BIT, t16c_pkg::TOP_10BIT};
		for (int i = 0; i < 3; i++) begin
			apb(1, t16c_pkg::ADDR_CTRL, ctl(4'(5 + i), 1'b0, 1'b0));
			apb(1, t16c_pkg::ADDR_CMPA, 32'hFFFF);
			apb(0, t16c_pkg::ADDR_CMPA, 0);
			check(rd, {16'h0000, tops[i]}, "compare masked");
			apb(1, t16c_pkg::ADDR_CMPB, 32'h0010);
			apb(1, t16c_pkg::ADDR_COUNT, 0);
			apb(1, t16c_pkg::ADDR_FLAGS, 32'hF);
			observe(tops[i], 2 * int'(tops[i]) + 8, 1'b0);
			apb(0, t16c_pkg::ADDR_FLAGS, 0);
			check(rd[2:0], 3'h7, "overflow and compare flags");
		end
		$display("fixed top test done");
	endtask : t_fixed
	task automatic t_var();
		logic [15:0] c0, v;
		apb(1, t16c_pkg::ADDR_CTRL, ctl(4'h0, 1'b0, 1'b0));
		apb(1, t16c_pkg::ADDR_CMPA, 32'h0003);
		apb(1, t16c_pkg::ADDR_CTRL, ctl(t16c_pkg::MODE_FPWM_CMPA, 1'b0, 1'b0));
		apb(1, t16c_pkg::ADDR_COUNT, 0);
		observe(16'h0003, 20, 1'b1);
		apb(1, t16c_pkg::ADDR_CMPA, 32'h0040);
		observe(16'h0040, 140, 1'b1);
		wait_cnt(16'h0028, 200);
		apb(1, t16c_pkg::ADDR_CMPA, 32'h0020);
		observe(16'h0040, 40, 1'b0);
		observe(16'h0020, 100, 1'b1);
		apb(1, t16c_pkg::ADDR_CTRL, ctl(t16c_pkg::MODE_FPWM_CAPT, 1'b0, 1'b0));
		apb(1, t16c_pkg::ADDR_CAPT_HI, 0);
		apb(1, t16c_pkg::ADDR_CAPT_LO, 32'h0040);
		apb(1, t16c_pkg::ADDR_COUNT, 0);
		apb(1, t16c_pkg::ADDR_FLAGS, 32'hF);
		observe(16'h0040, 140, 1'b0);
		apb(0, t16c_pkg::ADDR_FLAGS, 0);
		check({rd[t16c_pkg::FLG_CAPT], rd[t16c_pkg::FLG_OVF]}, 2'h3, "top flag pair");
		wait_cnt(16'h0030, 200);
		apb(1, t16c_pkg::ADDR_CAPT_HI, 0);
		apb(1, t16c_pkg::ADDR_CAPT_LO, 32'h0020);
		wait_cnt(16'hFFFF, 70000);
		@(negedge clk);
		check(cnt, 16'h0000, "wrap past max");
		observe(16'h0020, 80, 1'b0);
		edge_on(1, 0, c0);
		edge_on(1, 1, c0);
		rd_cap(v);
		check(v, 16'h0020, "no capture with capture top");
		$display("variable top test done");
	endtask : t_var
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_capture();
		t_fixed();
		t_var();
		print_verdict();
	end
endmodule : t16c_top_bench
